/* design/adet_engine.sv */
// Activity detection engine: registers, rate timing, compare and sustain
`timescale 1ns/10ps
module adet_engine
  import adet_pkg::*;
#(
  parameter int unsigned BASE_CYC  = ODR_BASE_CYC,
  parameter int unsigned TICK_SLOW = TICK_SLOW_CYC,
  parameter int unsigned TICK_FAST = TICK_FAST_CYC
)(
  input  wire logic                    mclk,       // System clock
  input  wire logic                    rst,        // Async reset, high
  input  wire logic                    reg_wr,     // Register write strobe
  input  wire logic                    reg_rd,     // Register read strobe
  input  wire logic [7:0]              reg_addr,   // Register address
  input  wire logic [7:0]              reg_wdata,  // Write data
  output logic      [7:0]              reg_rdata,  // Read data, next cycle
  output logic                         adc_start,  // Conversion pulse
  input  wire logic                    raw_valid,  // Raw sample strobe
  input  wire logic signed [SMP_W-1:0] raw_x,      // Raw X sample
  input  wire logic signed [SMP_W-1:0] raw_y,      // Raw Y sample
  input  wire logic signed [SMP_W-1:0] raw_z,      // Raw Z sample
  output logic [2:0]                   eff_bw,     // Effective bandwidth
  output logic                         low_noise,  // Analog low-noise mode
  output logic [1:0]                   op_mode,    // Current mode
  output logic                         act_irq     // Activity interrupt
);
  logic [7:0]              thr_h_q [3], thr_h_d [3];
  logic [7:0]              thr_l_q [3], thr_l_d [3];
  logic [7:0]              activity_sustain_count_q, activity_sustain_count_d;
  logic [7:0]              act_ctl_q, act_ctl_d;
  logic                    int_en_q, int_en_d;
  logic [7:0]              mode_reg_q, mode_reg_d;
  logic [2:0]              output_sample_rate_q, output_sample_rate_d;
  logic [2:0]              bw_sel_q, bw_sel_d;
  logic                    act_flag_q, act_flag_d;
  logic [7:0]              rdata_q, rdata_d;
  logic [19:0]             odr_cnt_q, odr_cnt_d;
  logic                    start_q, start_d;
  logic [19:0]             tick_cyc_q, tick_cyc_d;
  logic [7:0]              tick_cnt_q, tick_cnt_d;
  logic                    over_q, over_d;
  logic signed [SMP_W-1:0] ref_q [3], ref_d [3];
  logic                    ref_ok_q, ref_ok_d;

  logic [1:0]  mode;
  logic        measuring;
  logic        waking;
  logic        activity_referenced_select;
  logic [19:0] odr_limit;
  logic [19:0] tick_limit;
  logic        tick;
  logic [2:0]  axis_over;
  logic        any_over;
  logic        detect;
  logic signed [SMP_W-1:0] smp [3];
  logic [7:0]  event_status_secondary;
  logic [7:0]  status_main;
  adet_smp_if filt ();
  adet_lpf u_lpf (
    .mclk     (mclk),
    .rst      (rst),
    .run      (mode != MODE_STANDBY),
    .lpf_on   (act_ctl_q[ACT_LPF_BIT]),
    .odr_sel  (output_sample_rate_q),
    .in_valid (raw_valid),
    .in_x     (raw_x),
    .in_y     (raw_y),
    .in_z     (raw_z),
    .out      (filt.src)
  );

  function automatic logic [SMP_W:0] mag(input logic signed [SMP_W:0] v);
    mag = v[SMP_W] ? -v : v;
  endfunction : mag

  assign mode      = mode_reg_q[1:0];
  assign measuring = (mode == MODE_MEASURE);
  assign waking    = (mode == MODE_WAKEUP);
  assign activity_referenced_select = thr_l_q[0][THR_L_REF_BIT];
  assign smp[0] = filt.x;
  assign smp[1] = filt.y;
  assign smp[2] = filt.z;

  // Rate period doubles per step below the top rate
  assign odr_limit  = 20'(BASE_CYC << (ODR_5120 - output_sample_rate_q));
  assign tick_limit = (output_sample_rate_q == ODR_5120) ? 20'(TICK_FAST)
                                                         : 20'(TICK_SLOW);
  assign tick = over_q & (tick_cyc_q == tick_limit - 20'h1);

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      logic signed [SMP_W:0] diff;
      logic [SMP_W:0]        thr;
      diff = '0;
      thr  = {2'h0, thr_h_q[i], thr_l_q[i][7:5]};
      if (activity_referenced_select && ref_ok_q) begin
        diff = {smp[i][SMP_W-1], smp[i]} - {ref_q[i][SMP_W-1], ref_q[i]};
      end else if (activity_referenced_select) begin
        // The sample taken as reference deviates from itself by nothing
        diff = '0;
      end else begin
        diff = {smp[i][SMP_W-1], smp[i]};
      end
      axis_over[i] = act_ctl_q[i] & (mag(diff) > thr);
    end
  end
  assign any_over = |axis_over;
  // Wake-up ignores the time setting; measure needs the sustain count
  assign detect = filt.valid & any_over & (waking
                  | (measuring & (activity_sustain_count_q == 8'h00
                  | tick_cnt_q >= activity_sustain_count_q)));

  always_comb begin
    odr_cnt_d = odr_cnt_q + 20'h1;
    start_d   = 1'b0;
    if (mode == MODE_STANDBY || odr_cnt_q >= odr_limit - 20'h1) begin
      odr_cnt_d = '0;
      start_d   = (mode != MODE_STANDBY);
    end
    over_d     = over_q;
    tick_cyc_d = tick_cyc_q;
    tick_cnt_d = tick_cnt_q;
    if (filt.valid) begin
      over_d = any_over & measuring;
    end
    if (!measuring || detect || (filt.valid && !any_over)) begin
      tick_cyc_d = '0;
      tick_cnt_d = '0;
      over_d     = 1'b0;
    end else if (tick) begin
      tick_cyc_d = '0;
      if (tick_cnt_q != 8'hff) begin
        tick_cnt_d = tick_cnt_q + 8'h1;
      end
    end else if (over_q) begin
      tick_cyc_d = tick_cyc_q + 20'h1;
    end
  end

  always_comb begin
    ref_ok_d = ref_ok_q;
    for (int i = 0; i < 3; i++) begin
      ref_d[i] = ref_q[i];
    end
    if (!activity_referenced_select) begin
      ref_ok_d = 1'b0;
    end else if (measuring && !ref_ok_q && filt.valid) begin
      ref_ok_d = 1'b1;
      for (int i = 0; i < 3; i++) begin
        ref_d[i] = smp[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      thr_h_d[i] = thr_h_q[i];
      thr_l_d[i] = thr_l_q[i];
    end
    activity_sustain_count_d = activity_sustain_count_q;
    act_ctl_d            = act_ctl_q;
    int_en_d             = int_en_q;
    mode_reg_d           = mode_reg_q;
    output_sample_rate_d = output_sample_rate_q;
    bw_sel_d             = bw_sel_q;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_THR_X_H:  thr_h_d[0] = reg_wdata;
        ADDR_THR_X_L:  thr_l_d[0] = reg_wdata;
        ADDR_THR_Y_H:  thr_h_d[1] = reg_wdata;
        ADDR_THR_Y_L:  thr_l_d[1] = reg_wdata;
        ADDR_THR_Z_H:  thr_h_d[2] = reg_wdata;
        ADDR_THR_Z_L:  thr_l_d[2] = reg_wdata;
        ADDR_ACT_TIME: activity_sustain_count_d = reg_wdata;
        ADDR_ACT_CTL:  act_ctl_d = reg_wdata;
        ADDR_INT_EN:   int_en_d = reg_wdata[0];
        ADDR_MODE:     mode_reg_d = reg_wdata;
        ADDR_TIMING: begin
          // Codes past the top rate are held off so the divider stays sane
          if (reg_wdata[2:0] <= ODR_5120) begin
            output_sample_rate_d = reg_wdata[2:0];
          end
          bw_sel_d = reg_wdata[5:3];
        end
        default: ;
      endcase
    end
    // Hardware wake wins over a same-cycle host write
    if (waking && detect) begin
      mode_reg_d[1:0] = MODE_MEASURE;
    end
  end

  always_comb begin
    act_flag_d = act_flag_q;
    if (reg_rd && reg_addr == ADDR_EVENT_STATUS_SECONDARY) begin
      act_flag_d = 1'b0;
    end
    // Wake-up detection flags only when no sustain time is asked for
    if (detect && (measuring || activity_sustain_count_q == 8'h00)) begin
      act_flag_d = 1'b1;
    end
    if (mode == MODE_STANDBY) begin
      act_flag_d = 1'b0;
    end
  end

  assign event_status_secondary = {7'h00, act_flag_q};
  assign status_main = {7'h00, measuring};

  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_STATUS:   rdata_d = status_main;
        ADDR_EVENT_STATUS_SECONDARY:  rdata_d = event_status_secondary;
        ADDR_THR_X_H:  rdata_d = thr_h_q[0];
        ADDR_THR_X_L:  rdata_d = thr_l_q[0];
        ADDR_THR_Y_H:  rdata_d = thr_h_q[1];
        ADDR_THR_Y_L:  rdata_d = thr_l_q[1];
        ADDR_THR_Z_H:  rdata_d = thr_h_q[2];
        ADDR_THR_Z_L:  rdata_d = thr_l_q[2];
        ADDR_ACT_TIME: rdata_d = activity_sustain_count_q;
        ADDR_ACT_CTL:  rdata_d = act_ctl_q;
        ADDR_INT_EN:   rdata_d = {7'h00, int_en_q};
        ADDR_MODE:     rdata_d = mode_reg_q;
        ADDR_TIMING:   rdata_d = {2'h0, bw_sel_q, output_sample_rate_q};
        default:       rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        thr_h_q[i] <= REG_RESET;
        thr_l_q[i] <= REG_RESET;
        ref_q[i]   <= '0;
      end
      activity_sustain_count_q <= REG_RESET;
      act_ctl_q            <= REG_RESET;
      int_en_q             <= 1'b0;
      mode_reg_q           <= REG_RESET;
      output_sample_rate_q <= ODR_320;
      bw_sel_q             <= BW_160;
      act_flag_q           <= 1'b0;
      rdata_q              <= REG_RESET;
      odr_cnt_q            <= '0;
      start_q              <= 1'b0;
      tick_cyc_q           <= '0;
      tick_cnt_q           <= '0;
      over_q               <= 1'b0;
      ref_ok_q             <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        thr_h_q[i] <= thr_h_d[i];
        thr_l_q[i] <= thr_l_d[i];
        ref_q[i]   <= ref_d[i];
      end
      activity_sustain_count_q <= activity_sustain_count_d;
      act_ctl_q            <= act_ctl_d;
      int_en_q             <= int_en_d;
      mode_reg_q           <= mode_reg_d;
      output_sample_rate_q <= output_sample_rate_d;
      bw_sel_q             <= bw_sel_d;
      act_flag_q           <= act_flag_d;
      rdata_q              <= rdata_d;
      odr_cnt_q            <= odr_cnt_d;
      start_q              <= start_d;
      tick_cyc_q           <= tick_cyc_d;
      tick_cnt_q           <= tick_cnt_d;
      over_q               <= over_d;
      ref_ok_q             <= ref_ok_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign adc_start = start_q;
  // Bandwidth code k is 160*2^k Hz, so half the rate is code odr_sel
  assign eff_bw = (bw_sel_q > output_sample_rate_q) ? output_sample_rate_q
                                                    : bw_sel_q;
  assign low_noise = mode_reg_q[LOW_NOISE_BIT];
  assign op_mode   = mode;
  assign act_irq   = act_flag_q & int_en_q & measuring;

  bw_clamp_a: assert property (@(posedge mclk) disable iff (rst)
    eff_bw <= output_sample_rate_q && eff_bw <= bw_sel_q)
    else $error("bandwidth above half the rate");
  no_irq_wake_a: assert property (@(posedge mclk) disable iff (rst)
    !measuring |-> !act_irq)
    else $error("interrupt outside measurement mode");
  stby_clear_a: assert property (@(posedge mclk) disable iff (rst)
    mode == MODE_STANDBY |=> !act_flag_q)
    else $error("flag survives standby");
  wake_switch_a: assert property (@(posedge mclk) disable iff (rst)
    waking && filt.valid && any_over |=> measuring)
    else $error("wake-up detection did not enter measurement");
  flag_set_a: assert property (@(posedge mclk) disable iff (rst)
    measuring && detect |=> act_flag_q)
    else $error("activity flag not set");
  zero_time_a: assert property (@(posedge mclk) disable iff (rst)
    measuring && filt.valid && any_over && activity_sustain_count_q == 8'h00
    |=> act_flag_q)
    else $error("zero time missed single sample");
  sustain_req_a: assert property (@(posedge mclk) disable iff (rst)
    measuring && detect && activity_sustain_count_q != 8'h00
    |-> tick_cnt_q >= activity_sustain_count_q)
    else $error("activity before sustain time");
  timer_idle_a: assert property (@(posedge mclk) disable iff (rst)
    !measuring |=> tick_cnt_q == 8'h00 && tick_cyc_q == 20'h0)
    else $error("sustain timer ran outside measurement");
  ref_drop_a: assert property (@(posedge mclk) disable iff (rst)
    !activity_referenced_select |=> !ref_ok_q)
    else $error("reference kept in absolute mode");
  ref_take_a: assert property (@(posedge mclk) disable iff (rst)
    activity_referenced_select && measuring && !ref_ok_q && filt.valid
    |=> ref_ok_q && ref_q[0] == $past(smp[0]))
    else $error("reference not captured");
  rate_pulse_a: assert property (@(posedge mclk) disable iff (rst)
    mode == MODE_STANDBY |=> !adc_start)
    else $error("conversion started in standby");
  tick_len_a: assert property (@(posedge mclk) disable iff (rst)
    tick |-> tick_cyc_q == tick_limit - 20'h1)
    else $error("timer tick at wrong length");
  awake_a: assert property (@(posedge mclk) disable iff (rst)
    status_main[0] == (op_mode == MODE_MEASURE))
    else $error("awake bit mismatch");

  c_wake_c: cover property (@(posedge mclk) disable iff (rst)
    waking && detect ##1 measuring);
  c_sustain_c: cover property (@(posedge mclk) disable iff (rst)
    measuring && detect && activity_sustain_count_q != 8'h00);
  c_irq_c: cover property (@(posedge mclk) disable iff (rst) act_irq);
  c_ref_c: cover property (@(posedge mclk) disable iff (rst)
    $rose(ref_ok_q));
endmodule : adet_engine

/* design/adet_pkg.sv */
// Constants, register map and field layout of the activity detect engine
package adet_pkg;
  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned ODR_MAX_HZ    = 5120;
  localparam int unsigned ODR_BASE_CYC  = CLK_HZ / ODR_MAX_HZ;
  localparam int unsigned TICK_SLOW_NS  = 8_250_000;
  localparam int unsigned TICK_FAST_NS  = 4_125_000;
  // Tick length in clocks: microseconds times clocks per microsecond
  localparam int unsigned TICK_SLOW_CYC =
    TICK_SLOW_NS / 1000 * (CLK_HZ / 1_000_000);
  localparam int unsigned TICK_FAST_CYC =
    TICK_FAST_NS / 1000 * (CLK_HZ / 1_000_000);
  localparam int unsigned SMP_W   = 12;
  localparam int unsigned THR_W   = 11;
  localparam int unsigned LPF_FRAC = 8;
  localparam logic [2:0] LPF_SHIFT_320 = 3'h3;

  localparam logic [7:0] ADDR_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_EVENT_STATUS_SECONDARY  = 8'h05;
  localparam logic [7:0] ADDR_THR_X_H  = 8'h23;
  localparam logic [7:0] ADDR_THR_X_L  = 8'h24;
  localparam logic [7:0] ADDR_THR_Y_H  = 8'h25;
  localparam logic [7:0] ADDR_THR_Y_L  = 8'h26;
  localparam logic [7:0] ADDR_THR_Z_H  = 8'h27;
  localparam logic [7:0] ADDR_THR_Z_L  = 8'h28;
  localparam logic [7:0] ADDR_ACT_TIME = 8'h29;
  localparam logic [7:0] ADDR_ACT_CTL  = 8'h2a;
  localparam logic [7:0] ADDR_INT_EN   = 8'h2b;
  localparam logic [7:0] ADDR_MODE     = 8'h2c;
  localparam logic [7:0] ADDR_TIMING   = 8'h2d;

  localparam int unsigned THR_L_REF_BIT = 1;
  localparam int unsigned ACT_LPF_BIT   = 3;
  localparam int unsigned LOW_NOISE_BIT = 2;

  localparam logic [1:0] MODE_STANDBY = 2'h0;
  localparam logic [1:0] MODE_WAKEUP  = 2'h1;
  localparam logic [1:0] MODE_MEASURE = 2'h2;
  localparam logic [2:0] ODR_320  = 3'h0;
  localparam logic [2:0] ODR_5120 = 3'h4;
  localparam logic [2:0] BW_160   = 3'h0;
  localparam logic [7:0] REG_RESET = 8'h00;
endpackage : adet_pkg

/* design/adet_smp_if.sv */
// Filtered sample bundle between the low-pass stage and the detector
`timescale 1ns/10ps
interface adet_smp_if;
  import adet_pkg::*;
  logic                    valid;
  logic signed [SMP_W-1:0] x;
  logic signed [SMP_W-1:0] y;
  logic signed [SMP_W-1:0] z;
  modport src (output valid, output x, output y, output z);
  modport dst (input valid, input x, input y, input z);
endinterface : adet_smp_if

/* design/adet_lpf.sv */
// Three-axis averaging low-pass with bypass for high-g detection
`timescale 1ns/10ps
module adet_lpf
  import adet_pkg::*;
(
  input  wire logic                    mclk,      // System clock
  input  wire logic                    rst,       // Async reset, high
  input  wire logic                    run,       // Low when in standby
  input  wire logic                    lpf_on,    // Averaging enabled
  input  wire logic [2:0]              odr_sel,   // Rate code
  input  wire logic                    in_valid,  // New raw sample
  input  wire logic signed [SMP_W-1:0] in_x,      // Raw X
  input  wire logic signed [SMP_W-1:0] in_y,      // Raw Y
  input  wire logic signed [SMP_W-1:0] in_z,      // Raw Z
  adet_smp_if.src                      out        // Filtered samples
);
  localparam int unsigned AW = SMP_W + LPF_FRAC;
  logic signed [AW-1:0] acc_q [3];
  logic signed [AW-1:0] acc_d [3];
  logic signed [SMP_W-1:0] raw [3];
  logic signed [SMP_W-1:0] res_q [3];
  logic signed [SMP_W-1:0] res_d [3];
  logic valid_q;
  logic valid_d;
  logic [2:0] shift;

  assign raw[0] = in_x;
  assign raw[1] = in_y;
  assign raw[2] = in_z;
  // Corner stays near 6.4 Hz: one more shift per doubling of the rate
  assign shift = 3'(LPF_SHIFT_320 + odr_sel);

  always_comb begin
    valid_d = run & in_valid;
    for (int i = 0; i < 3; i++) begin
      acc_d[i] = acc_q[i];
      res_d[i] = res_q[i];
      if (!run) begin
        acc_d[i] = '0;
      end else if (in_valid) begin
        if (lpf_on) begin
          // Signed error, so the shift keeps the sign of a falling step
          acc_d[i] = acc_q[i] + (($signed({raw[i], {LPF_FRAC{1'b0}}})
                     - acc_q[i]) >>> shift);
          res_d[i] = acc_d[i][AW-1:LPF_FRAC];
        end else begin
          acc_d[i] = {raw[i], {LPF_FRAC{1'b0}}};
          res_d[i] = raw[i];
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      valid_q <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        acc_q[i] <= '0;
        res_q[i] <= '0;
      end
    end else begin
      valid_q <= valid_d;
      for (int i = 0; i < 3; i++) begin
        acc_q[i] <= acc_d[i];
        res_q[i] <= res_d[i];
      end
    end
  end

  assign out.valid = valid_q;
  assign out.x     = res_q[0];
  assign out.y     = res_q[1];
  assign out.z     = res_q[2];
endmodule : adet_lpf

/* testbench/adet_src_model.sv */
// Sample source that answers each conversion pulse with one sample
`timescale 1ns/10ps
module adet_src_model
  import adet_pkg::*;
(
  input  wire logic                    mclk,  // System clock
  input  wire logic                    start, // Conversion pulse
  input  wire logic signed [SMP_W-1:0] lvl,   // Level to report
  output logic                         valid, // Sample strobe
  output logic signed [SMP_W-1:0]      sx,    // X sample
  output logic signed [SMP_W-1:0]      sy,    // Y sample
  output logic signed [SMP_W-1:0]      sz     // Z sample
);
  initial begin
    valid = 1'b0;
    sx    = '0;
    sy    = '0;
    sz    = '0;
  end
  // Between strobes the lines toggle so a stale sample is never trusted
  always @(posedge mclk) begin
    valid <= start;
    sx    <= start ? lvl : ~sx;
    sy    <= start ? lvl : ~sy;
    sz    <= start ? lvl : ~sz;
  end
endmodule : adet_src_model

/* testbench/activity_detect_engine_tb.sv */
// Self-checking bench for the activity detect engine
`timescale 1ns/10ps
module activity_detect_engine_tb;
  import adet_pkg::*;
  logic                    mclk, rst, reg_wr, reg_rd, sn;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata;
  logic                    adc_start, raw_valid, low_noise, act_irq;
  logic signed [SMP_W-1:0] raw_x, raw_y, raw_z, lvl;
  logic [2:0]              eff_bw;
  logic [1:0]              op_mode;
  int                      fails, comparisons;

  adet_engine #(.BASE_CYC(8), .TICK_SLOW(20), .TICK_FAST(10)) dut (
    .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_start(adc_start), .raw_valid(raw_valid), .raw_x(raw_x),
    .raw_y(raw_y), .raw_z(raw_z), .eff_bw(eff_bw),
    .low_noise(low_noise), .op_mode(op_mode), .act_irq(act_irq));
  adet_src_model src (.mclk(mclk), .start(adc_start), .lvl(lvl),
    .valid(raw_valid), .sx(raw_x), .sy(raw_y), .sz(raw_z));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
    #1;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask : rd

  task automatic go(logic [1:0] m);
    wr(ADDR_MODE, {6'h0, m});
  endtask : go

  task automatic await_irq(int n);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      if (act_irq === 1'b1) begin
        comparisons++;
        return;
      end
    end
    chk("act_irq rise", {7'h0, act_irq}, 8'h01);
    stop_test();
  endtask : await_irq

  // A short glitch on the interrupt is caught, not only the final level
  task automatic quiet(int n);
    sn = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      #1;
      sn = sn | act_irq;
    end
    chk("act_irq quiet", {7'h0, sn}, 8'h00);
  endtask : quiet

  initial begin
    rst       = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    lvl       = '0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk("eff_bw", {5'h0, eff_bw}, 8'h00);
    chk("op_mode", {6'h0, op_mode}, 8'h00);
    for (int a = 'h23; a <= 'h2d; a++) begin
      rd(a[7:0], 8'h00);
    end
    rd(8'h3f, 8'h00);
    wr(ADDR_ACT_TIME, 8'ha5);
    rd(ADDR_ACT_TIME, 8'ha5);
    for (int r = 0; r < 5; r++) begin
      wr(ADDR_TIMING, {2'h0, 3'h3, r[2:0]});
      chk("eff_bw", {5'h0, eff_bw}, (r < 3) ? r[7:0] : 8'h03);
    end
    wr(ADDR_TIMING, 8'h25);
    rd(ADDR_TIMING, 8'h24);
    wr(ADDR_MODE, 8'h04);
    chk("low_noise", {7'h0, low_noise}, 8'h01);
    // All detection settings are made in standby only
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_TIMING, 8'h04);
    wr(ADDR_THR_X_H, 8'h01);
    wr(ADDR_ACT_CTL, 8'h01);
    wr(ADDR_INT_EN, 8'h01);
    wr(ADDR_ACT_TIME, 8'h00);
    lvl <= 12'sd8;
    go(MODE_MEASURE);
    quiet(40);
    lvl <= -12'sd9;
    await_irq(40);
    rd(ADDR_STATUS, 8'h01);
    lvl <= 12'sd0;
    repeat (20) @(posedge mclk);
    rd(ADDR_EVENT_STATUS_SECONDARY, 8'h01);
    rd(ADDR_EVENT_STATUS_SECONDARY, 8'h00);
    lvl <= 12'sd20;
    await_irq(40);
    go(MODE_STANDBY);
    chk("act_irq", {7'h0, act_irq}, 8'h00);
    rd(ADDR_EVENT_STATUS_SECONDARY, 8'h00);
    wr(ADDR_THR_X_H, 8'h7f);
    wr(ADDR_THR_Z_H, 8'h01);
    wr(ADDR_ACT_CTL, 8'h05);
    wr(ADDR_ACT_TIME, 8'h02);
    go(MODE_MEASURE);
    // Two fast ticks plus sample spacing: irq only in this narrow window
    quiet(28);
    await_irq(12);
    go(MODE_STANDBY);
    wr(ADDR_ACT_TIME, 8'h00);
    lvl <= 12'sd0;
    go(MODE_WAKEUP);
    chk("op_mode", {6'h0, op_mode}, 8'h01);
    lvl <= 12'sd20;
    sn = 1'b0;
    for (int i = 0; i < 60 && op_mode !== MODE_MEASURE; i++) begin
      @(posedge mclk);
      #1;
      if (op_mode === MODE_WAKEUP) sn = sn | act_irq;
    end
    chk("op_mode", {6'h0, op_mode}, 8'h02);
    chk("wake irq", {7'h0, sn}, 8'h00);
    await_irq(20);
    go(MODE_STANDBY);
    wr(ADDR_ACT_CTL, 8'h01);
    wr(ADDR_THR_X_H, 8'h01);
    // Model data is settled from its first sample, so select may lead entry
    wr(ADDR_THR_X_L, 8'h02);
    lvl <= 12'sd100;
    go(MODE_MEASURE);
    quiet(40);
    lvl <= 12'sd109;
    await_irq(40);
    go(MODE_STANDBY);
    wr(ADDR_THR_X_L, 8'h00);
    wr(ADDR_THR_X_L, 8'h02);
    lvl <= 12'sd50;
    go(MODE_MEASURE);
    quiet(40);
    // Averaging on: a negative step needs about ten samples to cross
    go(MODE_STANDBY);
    wr(ADDR_THR_X_L, 8'h00);
    wr(ADDR_ACT_CTL, 8'h09);
    lvl <= -12'sd100;
    go(MODE_MEASURE);
    quiet(60);
    await_irq(100);
    stop_test();
  end
endmodule : activity_detect_engine_tb
